// >>> tb/tb_vocoder_config_strap_select.sv
// self-checking testbench for the configuration and strap select block
`timescale 1ns/1ps
module tb_vocoder_config_strap_select;
  reg         i_clk_sys = 1'b0;
  reg         i_hw_reset_n = 1'b0;
  reg  [3:0]  i_addr = 4'h0;
  reg  [31:0] i_wdata = 32'h0;
  reg         i_wr = 1'b0, i_rd = 1'b0, i_enc_level_stb = 1'b0, i_dec_silence_stb = 1'b0;
  reg  [7:0]  i_enc_level = 8'h0, i_dec_noise_level = 8'h0;
  reg  [15:0] i_enc_sample = 16'h0, i_dec_sample = 16'h0;
  reg  [2:0]  b_code = 3'h0;
  reg  [5:0]  b_rate = 6'h0;
  reg  [3:0]  b_feat = 4'h0;
  reg         b_load = 1'b0;
  wire [2:0]  sel;
  wire [5:0]  i_rate_sel;
  wire [3:0]  feat;
  wire        i_iface_sel_bit0 = sel[0], i_iface_sel_bit1 = sel[1], i_iface_sel_bit2 = sel[2];
  wire        i_silence_suppress_en = feat[0], i_echo_cancel_en = feat[1];
  wire        i_companding_en = feat[2], i_companding_law_sel = feat[3];
  wire [31:0] o_rdata;
  wire        o_cfg_valid, o_packet_mode, o_rate_custom, o_vad_on, o_ec_on, o_sample_tick;
  wire        o_enc_voice, o_enc_silence_stb, o_dec_cni_stb, o_ec_valid;
  wire [2:0]  o_codec_iface, o_packet_iface;
  wire [1:0]  o_sample_fmt;
  wire [5:0]  o_rate_preset;
  wire [7:0]  o_voice_units, o_fec_units, o_noise_level, o_dec_cni_level;
  wire [15:0] o_ec_sample;
  integer     fails = 0, n_tests = 0, cyc = 0;
  reg  [31:0] q;
  // expected {packet mode, codec link, packet link} per select code
  localparam [55:0] EXP_IF = {7'h42, 7'h44, 7'h43, 7'h14, 7'h13, 7'h0a, 7'h0c, 7'h0b};

  vcs_cfg_top #(.WIN_CYC(64), .SMP_CYC(200)) u_vcs_cfg_top (.*);
  vcs_strap_board u_vcs_strap_board (.i_clk_sys(i_clk_sys), .i_load(b_load), .i_code(b_code),
    .i_rate(b_rate), .i_feat(b_feat), .o_sel(sel), .o_rate(i_rate_sel), .o_feat(feat));

  // 250 MHz clock and run ceiling
  always #2 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      fails = fails + 1;
      end_sim;
    end
  end
  // ********************************
  // shared tasks
  // ********************************
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge i_clk_sys);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
      repeat (2) @(posedge i_clk_sys);
      #1;
    end
  endtask
  task rd(input [3:0] a, output [31:0] d);
    begin
      @(posedge i_clk_sys);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      #1;
      d = o_rdata;
    end
  endtask
  task lvl(input [7:0] l);
    begin
      @(posedge i_clk_sys);
      i_enc_level_stb <= 1'b1;
      i_enc_level <= l;
      @(posedge i_clk_sys);
      i_enc_level_stb <= 1'b0;
      #1;
    end
  endtask
  task do_cfg(input [2:0] c, input [5:0] r, input [3:0] f);
    integer k;
    begin
      @(posedge i_clk_sys);
      i_hw_reset_n <= 1'b0;
      b_code <= c;
      b_rate <= r;
      b_feat <= f;
      b_load <= 1'b1;
      @(posedge i_clk_sys);
      b_load <= 1'b0;
      repeat (19) @(posedge i_clk_sys);
      i_hw_reset_n <= 1'b1;
      for (k = 0; k < 200 && o_cfg_valid !== 1'b1; k = k + 1)
        @(posedge i_clk_sys);
      #1;
      chk(o_cfg_valid, 1'b1);
    end
  endtask
  // ********************************
  // scenarios
  // ********************************
  task t_decode;
    integer c;
    begin
      for (c = 0; c < 8; c = c + 1) begin
        do_cfg(c[2:0], {c[2:0], 3'h5}, {c[0], c[2], c[1], c[0]});
        chk({o_packet_mode, o_codec_iface, o_packet_iface}, EXP_IF[c*7 +: 7]);
        chk(o_rate_preset, {c[2:0], 3'h5});
        chk(o_sample_fmt, c[2] ? (c[0] ? 2'h2 : 2'h1) : 2'h0);
        chk({o_vad_on, o_ec_on, o_rate_custom}, {c[0], c[1], 1'b0});
      end
    end
  endtask
  task t_regs;
    begin
      rd(4'h0, q);
      chk(q[21:0], 22'h000945);
      wr(4'h4, 32'h0001_1030);
      chk({o_rate_custom, o_fec_units, o_voice_units}, 17'h11030);
      rd(4'h4, q);
      chk(q[16:0], 17'h11030);
      wr(4'h8, 32'h0000_007b);
      chk({o_vad_on, o_ec_on, o_sample_fmt}, 4'ha);
      wr(4'h0, 32'hffff_ffff);
      rd(4'h0, q);
      chk(q[7:0], 8'h45);
      rd(4'h2, q);
      chk(q, 32'h0);
    end
  endtask
  task t_vad;
    begin
      lvl(8'hf6);
      chk({o_enc_voice, o_enc_silence_stb}, 2'b10);
      lvl(8'h9c);
      chk({o_enc_voice, o_enc_silence_stb}, 2'b01);
      wr(4'h8, 32'h0000_007a);
      lvl(8'h9c);
      chk(o_enc_silence_stb, 1'b0);
      @(posedge i_clk_sys);
      i_dec_silence_stb <= 1'b1;
      i_dec_noise_level <= 8'h55;
      @(posedge i_clk_sys);
      i_dec_silence_stb <= 1'b0;
      #1;
      chk({o_dec_cni_stb, o_dec_cni_level}, 9'h155);
      rd(4'hc, q);
      chk(q, 32'h0000_01c2);
    end
  endtask
  task t_echo;
    integer k;
    begin
      @(posedge i_clk_sys);
      i_enc_sample <= 16'h1234;
      i_dec_sample <= 16'h0777;
      @(posedge i_clk_sys);
      #1;
      // wait for a tick that takes the new samples, then for its answer
      for (k = 0; k < 300 && o_sample_tick !== 1'b1; k = k + 1) begin
        @(posedge i_clk_sys);
        #1;
      end
      for (k = 0; k < 300 && o_ec_valid !== 1'b1; k = k + 1) begin
        @(posedge i_clk_sys);
        #1;
      end
      chk({o_ec_valid, o_ec_sample}, 17'h11234);
    end
  endtask
  task t_ignore;
    begin
      @(posedge i_clk_sys);
      b_code <= 3'h7;
      b_rate <= 6'h3d;
      b_feat <= 4'hf;
      b_load <= 1'b1;
      @(posedge i_clk_sys);
      b_load <= 1'b0;
      repeat (30) @(posedge i_clk_sys);
      #1;
      chk({o_packet_mode, o_codec_iface, o_packet_iface, o_rate_preset}, 13'h0280);
    end
  endtask
  task end_sim;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // main sequence
  initial begin
    t_decode;
    do_cfg(3'h2, 6'h00, 4'h6);
    t_regs;
    t_vad;
    t_echo;
    t_ignore;
    end_sim;
  end
endmodule

// >>> tb/vcs_cfg_top_properties.sv
// concurrent checks on the ports of the configuration block
`timescale 1ns/1ps
module vcs_cfg_props #(
  parameter WIN_CYC = 64,
  parameter SMP_CYC = 200
) (
  input wire        i_clk_sys,
  input wire        i_hw_reset_n,
  input wire        i_rd,
  input wire [31:0] o_rdata,
  input wire        o_cfg_valid,
  input wire        o_packet_mode,
  input wire [2:0]  o_codec_iface,
  input wire [2:0]  o_packet_iface,
  input wire        o_vad_on,
  input wire        o_sample_tick,
  input wire        i_enc_level_stb,
  input wire [7:0]  i_enc_level,
  input wire        o_enc_voice,
  input wire        o_enc_silence_stb,
  input wire        i_dec_silence_stb,
  input wire [7:0]  i_dec_noise_level,
  input wire        o_dec_cni_stb,
  input wire [7:0]  o_dec_cni_level,
  input wire        o_ec_valid
);
  // cycles since reset release (saturating) and gap between sample ticks
  reg [31:0] cnt_r;
  reg [31:0] gap_r;
  reg        seen_r;
  always @(posedge i_clk_sys or negedge i_hw_reset_n) begin
    if (!i_hw_reset_n) begin
      cnt_r  <= 32'h0;
      gap_r  <= 32'h0;
      seen_r <= 1'b0;
    end else begin
      if (cnt_r != WIN_CYC + 3)
        cnt_r <= cnt_r + 32'h1;
      gap_r  <= o_sample_tick ? 32'h0 : gap_r + 32'h1;
      seen_r <= seen_r | o_sample_tick;
    end
  end
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_hw_reset_n);
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data not zero outside read answer");
  a_window_shut: assert property ((cnt_r < WIN_CYC) |-> !o_cfg_valid)
    else $error("configuration valid inside sampling window");
  a_window_done: assert property ((cnt_r == WIN_CYC + 2) |-> o_cfg_valid)
    else $error("configuration not latched after window");
  a_cfg_hold: assert property (o_cfg_valid && $past(o_cfg_valid)
    |-> $stable({o_packet_mode, o_codec_iface, o_packet_iface}))
    else $error("latched interface selection changed");
  a_bsp_once: assert property (o_cfg_valid |-> !(o_codec_iface == 3'h2 && o_packet_iface == 3'h2))
    else $error("buffered serial port in both roles");
  a_pkt_single: assert property (o_cfg_valid && o_packet_mode
    |-> o_codec_iface == 3'h0 && o_packet_iface != 3'h0)
    else $error("packet mode interface use wrong");
  a_codec_pair: assert property (o_cfg_valid && !o_packet_mode
    |-> o_codec_iface != 3'h0 && o_packet_iface != 3'h0)
    else $error("codec mode lacks two interfaces");
  a_cni_follow: assert property (i_dec_silence_stb
    |=> o_dec_cni_stb && o_dec_cni_level == $past(i_dec_noise_level))
    else $error("comfort noise not produced for silence frame");
  a_loud_voice: assert property (i_enc_level_stb && ($signed(i_enc_level) > $signed(8'he7))
    |=> o_enc_voice && !o_enc_silence_stb)
    else $error("loud frame not classed as voice");
  a_silence_gate: assert property (o_enc_silence_stb |-> $past(i_enc_level_stb) && $past(o_vad_on))
    else $error("silence frame without enabled detection");
  a_tick_gap: assert property (o_sample_tick && seen_r |-> gap_r == SMP_CYC - 1)
    else $error("sample tick period wrong");
  a_ec_answer: assert property (o_sample_tick |-> ##129 o_ec_valid)
    else $error("echo canceller result late or missing");
endmodule
bind vcs_cfg_top vcs_cfg_props #(.WIN_CYC(WIN_CYC), .SMP_CYC(SMP_CYC)) u_vcs_cfg_props (.*);

// >>> tb/vcs_strap_board.sv
// board strap model: configuration pins change only when loaded
`timescale 1ns/1ps
module vcs_strap_board (
  input  wire       i_clk_sys,
  input  wire       i_load,
  input  wire [2:0] i_code,
  input  wire [5:0] i_rate,
  input  wire [3:0] i_feat,
  output reg  [2:0] o_sel  = 3'h0,
  output reg  [5:0] o_rate = 6'h0,
  output reg  [3:0] o_feat = 4'h0
);
  // pins stay steady between loads, so the window sees one value
  always @(posedge i_clk_sys) begin
    if (i_load) begin
      o_sel  <= i_code;
      o_rate <= i_rate;
      o_feat <= i_feat;
    end
  end
endmodule

// >>> verilog/vcs_cfg_top.v
// vocoder start-up configuration, strap select and feature control
`timescale 1ns/1ps
`include "vcs_consts.vh"
module vcs_cfg_top #(
  parameter WIN_CYC = `VCS_WIN_CYC,
  parameter SMP_CYC = `VCS_SMP_CYC
) (
  input  wire        i_clk_sys,
  input  wire        i_hw_reset_n,
  // straps
  input  wire        i_iface_sel_bit0,
  input  wire        i_iface_sel_bit1,
  input  wire        i_iface_sel_bit2,
  input  wire [5:0]  i_rate_sel,
  input  wire        i_silence_suppress_en,
  input  wire        i_echo_cancel_en,
  input  wire        i_companding_en,
  input  wire        i_companding_law_sel,
  // register port
  input  wire [3:0]  i_addr,
  input  wire [31:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [31:0] o_rdata,
  // configuration results
  output reg         o_cfg_valid,
  output reg         o_packet_mode,
  output reg  [2:0]  o_codec_iface,
  output reg  [2:0]  o_packet_iface,
  output reg  [1:0]  o_sample_fmt,
  output reg         o_rate_custom,
  output reg  [5:0]  o_rate_preset,
  output reg  [7:0]  o_voice_units,
  output reg  [7:0]  o_fec_units,
  output reg         o_vad_on,
  output reg         o_ec_on,
  output reg         o_sample_tick,
  // voice activity and comfort noise
  input  wire        i_enc_level_stb,
  input  wire [7:0]  i_enc_level,
  output reg         o_enc_voice,
  output reg         o_enc_silence_stb,
  output reg  [7:0]  o_noise_level,
  input  wire        i_dec_silence_stb,
  input  wire [7:0]  i_dec_noise_level,
  output reg         o_dec_cni_stb,
  output reg  [7:0]  o_dec_cni_level,
  // echo canceller samples
  input  wire [15:0] i_enc_sample,
  input  wire [15:0] i_dec_sample,
  output wire [15:0] o_ec_sample,
  output wire        o_ec_valid
);
  // ********************************
  // interface select decode
  // ********************************
  // returns {packet_mode, codec_iface, packet_iface}
  function [6:0] vcs_if_dec;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: vcs_if_dec = {1'b0, `VCS_IF_SPI, `VCS_IF_UART};  // R06
        3'h1: vcs_if_dec = {1'b0, `VCS_IF_SPI, `VCS_IF_PAR};   // R06
        3'h2: vcs_if_dec = {1'b0, `VCS_IF_SPI, `VCS_IF_BSP};   // R06
        3'h3: vcs_if_dec = {1'b0, `VCS_IF_BSP, `VCS_IF_UART};  // R07
        3'h4: vcs_if_dec = {1'b0, `VCS_IF_BSP, `VCS_IF_PAR};   // R07
        3'h5: vcs_if_dec = {1'b1, `VCS_IF_NONE, `VCS_IF_UART}; // R07
        3'h6: vcs_if_dec = {1'b1, `VCS_IF_NONE, `VCS_IF_PAR};  // R07
        default: vcs_if_dec = {1'b1, `VCS_IF_NONE, `VCS_IF_BSP}; // R07
      endcase
    end
  endfunction

  // ********************************
  // sampling window
  // ********************************
  wire win_open;
  wire win_close;

  vcs_win_timer #(
    .WIN_CYC (WIN_CYC),
    .CW      (21)
  ) u_win (
    .i_clk_sys (i_clk_sys),
    .i_hw_reset_n  (i_hw_reset_n),
    .o_open    (win_open),
    .o_close   (win_close)
  );

  // ********************************
  // strap shadow and latch
  // ********************************
  reg [2:0] sh_sel_r;
  reg [5:0] sh_rate_r;
  reg       sh_vad_r;
  reg       sh_ec_r;
  reg       sh_cen_r;
  reg       sh_law_r;
  reg       st_vad_r;
  reg       st_ec_r;
  reg       st_cen_r;
  reg       st_law_r;
  wire [6:0] if_nxt = vcs_if_dec(sh_sel_r);

  // straps are looked at only while the window is open
  always @(posedge i_clk_sys or negedge i_hw_reset_n) begin
    if (!i_hw_reset_n) begin
      sh_sel_r  <= 3'h0;
      sh_rate_r <= 6'h00;
      sh_vad_r  <= 1'b0;
      sh_ec_r   <= 1'b0;
      sh_cen_r  <= 1'b0;
      sh_law_r  <= 1'b0;
    end else if (win_open) begin // R09
      sh_sel_r  <= {i_iface_sel_bit2, i_iface_sel_bit1, i_iface_sel_bit0};
      sh_rate_r <= i_rate_sel;
      sh_vad_r  <= i_silence_suppress_en;
      sh_ec_r   <= i_echo_cancel_en;
      sh_cen_r  <= i_companding_en;
      sh_law_r  <= i_companding_law_sel;
    end
  end

  // settings frozen at window close until the next reset
  always @(posedge i_clk_sys or negedge i_hw_reset_n) begin
    if (!i_hw_reset_n) begin
      o_cfg_valid    <= 1'b0;
      o_packet_mode  <= 1'b0;
      o_codec_iface  <= `VCS_IF_NONE;
      o_packet_iface <= `VCS_IF_NONE;
      o_rate_preset  <= 6'h00;
      st_vad_r       <= 1'b0;
      st_ec_r        <= 1'b0;
      st_cen_r       <= 1'b0;
      st_law_r       <= 1'b0;
    end else if (win_close) begin // R20
      o_cfg_valid    <= 1'b1;
      o_packet_mode  <= if_nxt[6];   // R05
      o_codec_iface  <= if_nxt[5:3]; // R03 R04
      o_packet_iface <= if_nxt[2:0]; // R03
      // out-of-range preset codes fall back to preset 0
      o_rate_preset  <= (sh_rate_r < `VCS_PRESETS) ? sh_rate_r : 6'h00; // R01
      st_vad_r       <= sh_vad_r;
      st_ec_r        <= sh_ec_r;
      st_cen_r       <= sh_cen_r;
      st_law_r       <= sh_law_r;
    end
  end

  // ********************************
  // control registers
  // ********************************
  reg [7:0] voice_r;
  reg [7:0] fec_r;
  reg       cust_r;
  reg [6:0] feat_r;

  // software writes stand in for control packets
  always @(posedge i_clk_sys or negedge i_hw_reset_n) begin
    if (!i_hw_reset_n) begin
      voice_r <= 8'h00;
      fec_r   <= 8'h00;
      cust_r  <= 1'b0;
      feat_r  <= 7'h00;
    end else if (i_wr) begin
      if (i_addr == `VCS_A_RATE) begin
        voice_r <= i_wdata[7:0];  // R02
        fec_r   <= i_wdata[15:8]; // R02
        cust_r  <= i_wdata[`VCS_RATE_CUST];
      end else if (i_addr == `VCS_A_FEAT) begin
        feat_r <= i_wdata[6:0];
      end
    end
  end

  // ********************************
  // effective settings
  // ********************************
  wire cmp_en  = feat_r[`VCS_F_CMP_OVR] ? feat_r[`VCS_F_CMP_EN] : st_cen_r;
  wire cmp_law = feat_r[`VCS_F_CMP_OVR] ? feat_r[`VCS_F_CMP_LAW] : st_law_r;

  // register override wins over the latched strap
  always @(posedge i_clk_sys or negedge i_hw_reset_n) begin
    if (!i_hw_reset_n) begin
      o_vad_on      <= 1'b0;
      o_ec_on       <= 1'b0;
      o_sample_fmt  <= `VCS_FMT_LIN16;
      o_rate_custom <= 1'b0;
      o_voice_units <= 8'h00;
      o_fec_units   <= 8'h00;
    end else begin
      o_vad_on      <= feat_r[`VCS_F_VAD_OVR] ? feat_r[`VCS_F_VAD_VAL] : st_vad_r; // R21
      o_ec_on       <= feat_r[`VCS_F_EC_OVR] ? feat_r[`VCS_F_EC_VAL] : st_ec_r;    // R16
      // one format drives both directions
      o_sample_fmt  <= !cmp_en ? `VCS_FMT_LIN16 :
                       (cmp_law ? `VCS_FMT_ALAW : `VCS_FMT_MULAW); // R08 R19
      o_rate_custom <= cust_r;
      o_voice_units <= voice_r;
      o_fec_units   <= fec_r;
    end
  end

  // ********************************
  // 8 kHz sample tick
  // ********************************
  reg [15:0] div_r;

  // divider from the system clock to the speech sample rate
  always @(posedge i_clk_sys or negedge i_hw_reset_n) begin
    if (!i_hw_reset_n) begin
      div_r         <= 16'h0000;
      o_sample_tick <= 1'b0;
    end else if (div_r == SMP_CYC[15:0] - 1'b1) begin // R18
      div_r         <= 16'h0000;
      o_sample_tick <= 1'b1;
    end else begin
      div_r         <= div_r + 1'b1;
      o_sample_tick <= 1'b0;
    end
  end

  // ********************************
  // voice activity detection
  // ********************************
  wire       lvl_hot = $signed(i_enc_level) > $signed(`VCS_VAD_THR);
  wire [7:0] nf_thr  = o_noise_level + `VCS_VAD_MARGIN;
  wire       lvl_adp = $signed(i_enc_level) > $signed(nf_thr);
  wire       is_voice = lvl_hot || lvl_adp;

  // classify each encoder frame and track the background level
  always @(posedge i_clk_sys or negedge i_hw_reset_n) begin
    if (!i_hw_reset_n) begin
      o_enc_voice       <= 1'b1;
      o_enc_silence_stb <= 1'b0;
      o_noise_level     <= `VCS_NF_INIT;
    end else begin
      o_enc_silence_stb <= 1'b0;
      if (i_enc_level_stb) begin
        o_enc_voice       <= is_voice || !o_vad_on; // R15
        o_enc_silence_stb <= !is_voice && o_vad_on; // R12
        if (!is_voice) begin
          // follow the noise floor one step per silent frame
          if ($signed(i_enc_level) > $signed(o_noise_level))
            o_noise_level <= o_noise_level + 8'h01;
          else if ($signed(i_enc_level) < $signed(o_noise_level))
            o_noise_level <= o_noise_level - 8'h01;
        end else if (!lvl_hot && $signed(nf_thr) < $signed(`VCS_VAD_THR)) begin
          // quiet voice lets the floor creep up
          o_noise_level <= o_noise_level + 8'h01; // R15
        end
      end
    end
  end

  // ********************************
  // comfort noise insertion
  // ********************************
  // decoder side works regardless of local vad state
  always @(posedge i_clk_sys or negedge i_hw_reset_n) begin
    if (!i_hw_reset_n) begin
      o_dec_cni_stb   <= 1'b0;
      o_dec_cni_level <= 8'h00;
    end else begin
      o_dec_cni_stb <= i_dec_silence_stb; // R13
      if (i_dec_silence_stb)
        o_dec_cni_level <= i_dec_noise_level;
    end
  end

  // ********************************
  // echo canceller
  // ********************************
  vcs_echo_lms #(
    .TAPS (`VCS_EC_TAPS),
    .AW   (7)
  ) u_ec (
    .i_clk_sys (i_clk_sys),
    .i_hw_reset_n  (i_hw_reset_n),
    .i_en      (o_ec_on),
    .i_tick    (o_sample_tick),
    .i_near    (i_enc_sample),
    .i_far     (i_dec_sample),
    .o_out     (o_ec_sample),
    .o_valid   (o_ec_valid)
  );

  // ********************************
  // register read back
  // ********************************
  // data stands only in the cycle after the read strobe
  always @(posedge i_clk_sys or negedge i_hw_reset_n) begin
    if (!i_hw_reset_n) begin
      o_rdata <= 32'h0;
    end else if (!i_rd) begin
      o_rdata <= 32'h0;
    end else if (i_addr == `VCS_A_STATUS) begin
      o_rdata <= {10'h0, o_rate_preset, 3'h0, o_rate_custom, o_ec_on, o_vad_on,
                  o_sample_fmt, o_packet_iface, o_codec_iface, o_packet_mode, o_cfg_valid};
    end else if (i_addr == `VCS_A_RATE) begin
      o_rdata <= {15'h0, cust_r, fec_r, voice_r};
    end else if (i_addr == `VCS_A_FEAT) begin
      o_rdata <= {25'h0, feat_r};
    end else if (i_addr == `VCS_A_VAD) begin
      o_rdata <= {23'h0, o_enc_voice, o_noise_level};
    end else begin
      o_rdata <= 32'h0;
    end
  end
endmodule

// >>> verilog/vcs_consts.vh
// constants for the vocoder start-up configuration and strap select block
// Overview of operation
// [R01] 62 preset voice/correction rates chosen by straps
// [R02] register rates set independently in 50 bps steps
// [R03] codec mode: codec link plus separate packet link
// [R04] buffered serial port never both codec and packet
// [R05] packet mode: one link carries all packets
// [R06] select codes 000-010: spi codec, three packet links
// [R07] 011-100 buffered codec; 101-111 packet mode
// [R08] one sample format shared by input and output
// [R09] straps sampled only first 7 ms after reset
// [R10] after window strap changes ignored until reset
// [R11] board holds straps steady during the window
// [R12] vad enabled: encoder emits silence frames with noise
// [R13] decoder inserts comfort noise on any silence frame
// [R14] far side resends silence frame every 500-1000 ms
// [R15] above -25 dBm0 voice, below adaptive threshold
// [R16] echo canceller switched by strap or register
// [R17] echo canceller: 128-tap 16 ms adaptive lms filter
// [R18] encoder and decoder sample at 8 kHz
// [R19] companding enable and law select pin meanings
// [R20] settings latched when window closes, held until reset
// [R21] register vad/echo setting overrides latched strap
`ifndef VCS_CONSTS_VH
`define VCS_CONSTS_VH
// ********************************
// timing
// ********************************
`define VCS_CLK_HZ      250000000
`define VCS_WIN_MS      7
`define VCS_WIN_CYC     ((`VCS_CLK_HZ / 1000) * `VCS_WIN_MS)
`define VCS_SMP_HZ      8000
`define VCS_SMP_CYC     (`VCS_CLK_HZ / `VCS_SMP_HZ)
`define VCS_EC_MS       16
`define VCS_EC_TAPS     128
`define VCS_RATE_STEP   50
`define VCS_PRESETS     6'h3e
// ********************************
// interface codes
// ********************************
`define VCS_IF_NONE     3'h0
`define VCS_IF_SPI      3'h1
`define VCS_IF_BSP      3'h2
`define VCS_IF_UART     3'h3
`define VCS_IF_PAR      3'h4
// ********************************
// sample formats
// ********************************
`define VCS_FMT_LIN16   2'h0
`define VCS_FMT_MULAW   2'h1
`define VCS_FMT_ALAW    2'h2
// ********************************
// register map and fields
// ********************************
`define VCS_A_STATUS    4'h0
`define VCS_A_RATE      4'h4
`define VCS_A_FEAT      4'h8
`define VCS_A_VAD       4'hc
`define VCS_RATE_CUST   16
`define VCS_F_VAD_VAL   0
`define VCS_F_VAD_OVR   1
`define VCS_F_EC_VAL    2
`define VCS_F_EC_OVR    3
`define VCS_F_CMP_EN    4
`define VCS_F_CMP_LAW   5
`define VCS_F_CMP_OVR   6
// ********************************
// voice activity and echo tuning
// ********************************
`define VCS_VAD_THR     8'he7
`define VCS_VAD_MARGIN  8'h06
`define VCS_NF_INIT     8'hc4
`define VCS_EC_STEP     16'h0004
`define VCS_EC_FRAC     15
`endif

// >>> verilog/vcs_echo_lms.v
// sequential adaptive lms echo canceller, one pass per sample
`timescale 1ns/1ps
`include "vcs_consts.vh"
module vcs_echo_lms #(
  parameter TAPS = `VCS_EC_TAPS,
  parameter AW   = 7
) (
  input  wire        i_clk_sys,
  input  wire        i_hw_reset_n,
  input  wire        i_en,
  input  wire        i_tick,
  input  wire [15:0] i_near,
  input  wire [15:0] i_far,
  output reg  [15:0] o_out,
  output reg         o_valid
);
  reg [15:0]        hist [0:TAPS-1];
  reg [15:0]        coef [0:TAPS-1];
  reg [AW-1:0]      wp_r;
  reg [AW-1:0]      k_r;
  reg               busy_r;
  reg               clr_r;
  reg               esgn_r;
  reg               enz_r;
  reg [15:0]        near_r;
  reg signed [39:0] acc_r;
  wire [AW-1:0]          hi  = wp_r - 1'b1 - k_r;
  wire [15:0]            h   = hist[hi];
  wire [15:0]            c   = coef[k_r];
  // all operands signed so the tap product keeps its sign in the sum
  wire signed [39:0]     acc_nxt = acc_r + ($signed(c) * $signed(h));
  wire signed [39:0]     est = acc_nxt >>> `VCS_EC_FRAC;
  wire signed [17:0]     err = $signed({{2{near_r[15]}}, near_r}) - $signed(est[17:0]);
  wire [15:0]            sat = (err > 18'sh07fff) ? 16'h7fff :
                               (err < -18'sh08000) ? 16'h8000 : err[15:0];

  // sign-sign update of each tap as it is accumulated, using last error
  always @(posedge i_clk_sys) begin
    if (i_tick)
      hist[wp_r] <= i_far;
    else if (busy_r && clr_r)
      hist[k_r] <= 16'h0000;
    if (busy_r) begin
      if (clr_r)
        coef[k_r] <= 16'h0000;
      else if (i_en && enz_r)
        coef[k_r] <= (esgn_r ^ h[15]) ? c - `VCS_EC_STEP : c + `VCS_EC_STEP; // R17
    end
  end

  // pass control: 128 taps per 8 kHz sample, first pass clears memory
  always @(posedge i_clk_sys or negedge i_hw_reset_n) begin
    if (!i_hw_reset_n) begin
      wp_r    <= {AW{1'b0}};
      k_r     <= {AW{1'b0}};
      busy_r  <= 1'b0;
      clr_r   <= 1'b1;
      esgn_r  <= 1'b0;
      enz_r   <= 1'b0;
      near_r  <= 16'h0000;
      acc_r   <= 40'h0;
      o_out   <= 16'h0000;
      o_valid <= 1'b0;
    end else begin
      o_valid <= 1'b0;
      if (i_tick) begin
        wp_r   <= wp_r + 1'b1;
        near_r <= i_near;
        acc_r  <= 40'h0;
        k_r    <= {AW{1'b0}};
        busy_r <= 1'b1;
      end else if (busy_r) begin
        acc_r <= acc_nxt;
        k_r   <= k_r + 1'b1;
        if (k_r == TAPS[AW-1:0] - 1'b1) begin
          busy_r  <= 1'b0;
          clr_r   <= 1'b0;
          o_valid <= 1'b1;
          if (i_en && !clr_r) begin // R16
            o_out  <= sat;
            esgn_r <= sat[15];
            enz_r  <= (sat != 16'h0000);
          end else begin
            o_out <= near_r;
            enz_r <= 1'b0;
          end
        end
      end
    end
  end
endmodule

// >>> verilog/vcs_win_timer.v
// strap sampling window timer started by reset release
`timescale 1ns/1ps
`include "vcs_consts.vh"
module vcs_win_timer #(
  parameter WIN_CYC = `VCS_WIN_CYC,
  parameter CW      = 21
) (
  input  wire i_clk_sys,
  input  wire i_hw_reset_n,
  output wire o_open,
  output reg  o_close
);
  reg [CW-1:0] cnt_r;
  reg          done_r;

  // count the window once per reset, then stop for good
  always @(posedge i_clk_sys or negedge i_hw_reset_n) begin
    if (!i_hw_reset_n) begin
      cnt_r   <= {CW{1'b0}};
      done_r  <= 1'b0;
      o_close <= 1'b0;
    end else begin
      o_close <= 1'b0;
      if (!done_r) begin
        if (cnt_r == WIN_CYC[CW-1:0] - 1'b1) begin // R09
          done_r  <= 1'b1;
          o_close <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end

  assign o_open = !done_r; // R10
endmodule
